// >>> shpr_pkg.sv
// Shared constants and types for the shared port pin readback block.
`default_nettype none

package shpr_pkg;

    // Register indices; the APB byte address of each register is four times its index.
    localparam logic [15:0] SHPR_IDX_DIR   = 16'hfe8c;
    localparam logic [15:0] SHPR_IDX_LATCH = 16'hfe8e;
    localparam logic [15:0] SHPR_IDX_AN4   = 16'hfe8f;
    localparam logic [15:0] SHPR_IDX_AN8   = 16'hfe92;
    localparam logic [15:0] SHPR_IDX_PCTL  = 16'hfede;
    localparam logic [15:0] SHPR_IDX_ISTAT = 16'hfef0;
    localparam logic [15:0] SHPR_IDX_IMASK = 16'hfef1;

    // Reset values and fixed read patterns.
    localparam logic [7:0]  SHPR_LATCH_RST = 8'h00;
    localparam logic [7:0]  SHPR_DIR_RST   = 8'h00;
    localparam logic [7:0]  SHPR_DIR_READ  = 8'hff;
    localparam logic [7:0]  SHPR_AN4_FILL  = 8'hf0;
    localparam logic [7:0]  SHPR_AN8_FILL  = 8'h00;
    localparam logic [7:0]  SHPR_PCTL_RSVD = 8'h3e;
    localparam logic [1:0]  SHPR_PWM_RST   = 2'h0;
    localparam logic [1:0]  SHPR_INT_RST   = 2'h0;

    // Pin positions of the bidirectional port.
    localparam int SHPR_BIT_IRQ_A = 0;
    localparam int SHPR_BIT_IRQ_B = 1;
    localparam int SHPR_BIT_TX_A  = 2;
    localparam int SHPR_BIT_RX_A  = 3;
    localparam int SHPR_BIT_TX_B  = 4;
    localparam int SHPR_BIT_RX_B  = 5;
    localparam int SHPR_BIT_CLK_A = 6;
    localparam int SHPR_BIT_CLK_B = 7;

    // Field positions in the port control register.
    localparam int SHPR_PCTL_PWM_A = 6;
    localparam int SHPR_PCTL_PWM_B = 7;

    // Sticky status bit positions, one per external interrupt pin.
    localparam int SHPR_INT_A = 0;
    localparam int SHPR_INT_B = 1;

    // One serial channel's claim on its pins.
    typedef struct packed {
        logic tx_en;
        logic tx_level;
        logic rx_en;
        logic clk_out_en;
        logic clk_in_en;
        logic clk_level;
    } shpr_serial_t;

    // Converter sampling status: which port and which channel is being sampled.
    typedef struct packed {
        logic       active;
        logic       on_eight;
        logic [2:0] chan;
    } shpr_conv_t;

    // All state of the top module.
    typedef struct packed {
        logic [7:0]  latch;
        logic [7:0]  dir;
        logic [1:0]  pwm_en;
        logic [1:0]  int_stat;
        logic [1:0]  int_mask;
        logic [1:0]  pin_prev;
        logic [7:0]  pin_out;
        logic [7:0]  pin_oe_n;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic [1:0]  ext_irq;
        logic        trig;
        logic [1:0]  rx;
        logic [1:0]  clk_in;
    } shpr_state_t;

    localparam shpr_state_t SHPR_STATE_RST = '{
        latch:    SHPR_LATCH_RST,
        dir:      SHPR_DIR_RST,
        pwm_en:   SHPR_PWM_RST,
        int_stat: SHPR_INT_RST,
        int_mask: SHPR_INT_RST,
        pin_prev: 2'h0,
        pin_out:  8'h00,
        pin_oe_n: 8'hff,
        prdata:   32'h0000_0000,
        pready:   1'b0,
        pslverr:  1'b0,
        irq:      1'b0,
        ext_irq:  2'h3,
        trig:     1'b1,
        rx:       2'h3,
        clk_in:   2'h0
    };

endpackage : shpr_pkg

`default_nettype wire

// >>> shpr_analog_readback.sv
// Read value of an input-only port shared with converter inputs.
`default_nettype none

module shpr_analog_readback #(
    parameter int         WIDTH    = 8,
    parameter logic [7:0] FILL     = 8'h00,
    parameter logic       IS_EIGHT = 1'b1
) (
    input  wire logic [WIDTH-1:0]    pin_level,
    input  wire shpr_pkg::shpr_conv_t conv,
    output logic [7:0]               level
);
    import shpr_pkg::*;

    // The port data fits one byte and a channel number of three bits.
    if (WIDTH < 1 || WIDTH > 8)
    begin : g_bad_width
        $error("shpr_analog_readback: WIDTH must lie between 1 and 8");
    end

    logic [WIDTH-1:0] bits;

    // A pin under conversion reads as 1, since its input buffer is cut off while sampling.
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        assign bits[i] = (conv.active && conv.on_eight == IS_EIGHT && conv.chan == 3'(i))
                         ? 1'b1 : pin_level[i];
    end

    // Unused upper positions take the fixed fill pattern.
    if (WIDTH < 8)
    begin : g_fill
        assign level = {FILL[7:WIDTH], bits};
    end
    else
    begin : g_full
        assign level = bits;
    end

endmodule : shpr_analog_readback

`default_nettype wire

// >>> shpr_port.sv
// Bidirectional shared port and two analog input ports behind an APB slave.
//
// The APB register port was left to the implementer.
`default_nettype none

module shpr_port (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       irq,
    input  wire logic [7:0]            pin_in,
    output logic [7:0]                 pin_out,
    output logic [7:0]                 pin_oe_n,
    input  wire logic [3:0]            analog_four_pin,
    input  wire logic [7:0]            analog_eight_pin,
    input  wire shpr_pkg::shpr_serial_t serial_a,
    input  wire shpr_pkg::shpr_serial_t serial_b,
    input  wire logic                  pulse_width_out_a,
    input  wire logic                  pulse_width_out_b,
    input  wire shpr_pkg::shpr_conv_t   conv,
    output logic                       ext_interrupt_in_a,
    output logic                       ext_interrupt_in_b,
    output logic                       converter_ext_trigger,
    output logic                       serial_rx_in_a,
    output logic                       serial_rx_in_b,
    output logic                       serial_clk_pin_a,
    output logic                       serial_clk_pin_b
);
    import shpr_pkg::*;

    shpr_state_t st_ff;
    shpr_state_t nxt_st;

    logic [7:0] periph_own;
    logic [7:0] periph_drive;
    logic [7:0] periph_val;
    logic [7:0] drive_en;
    logic [7:0] drive_val;
    logic [7:0] port_read;
    logic [7:0] an4_level;
    logic [7:0] an8_level;
    logic       pulse_width_out_a_enable;
    logic       pulse_width_out_b_enable;

    // True when the APB address selects the register at the given index.
    function automatic logic reg_hit(input logic [31:0] addr, input logic [15:0] idx);
        return addr == {14'h0000, idx, 2'b00};
    endfunction : reg_hit

    assign pulse_width_out_a_enable = st_ff.pwm_en[0];
    assign pulse_width_out_b_enable = st_ff.pwm_en[1];

    // Peripheral claims on each pin; the interrupt pins stay general purpose as well.
    always_comb
    begin
        periph_own   = 8'h00;
        periph_drive = 8'h00;
        periph_val   = 8'h00;
        // Serial transmit pins are driven by the serial channel.
        periph_own[SHPR_BIT_TX_A]   = serial_a.tx_en;
        periph_drive[SHPR_BIT_TX_A] = 1'b1;
        periph_val[SHPR_BIT_TX_A]   = serial_a.tx_level;
        periph_own[SHPR_BIT_TX_B]   = serial_b.tx_en;
        periph_drive[SHPR_BIT_TX_B] = 1'b1;
        periph_val[SHPR_BIT_TX_B]   = serial_b.tx_level;
        // Claimed receive pins are never driven, so a held-low break shows on reads.
        periph_own[SHPR_BIT_RX_A]   = serial_a.rx_en;
        periph_own[SHPR_BIT_RX_B]   = serial_b.rx_en;
        // The PWM output outranks any serial clock function on the same pin.
        periph_own[SHPR_BIT_CLK_A]   = pulse_width_out_a_enable
                                       | serial_a.clk_out_en | serial_a.clk_in_en;
        periph_drive[SHPR_BIT_CLK_A] = pulse_width_out_a_enable | serial_a.clk_out_en;
        periph_val[SHPR_BIT_CLK_A]   = pulse_width_out_a_enable
                                       ? pulse_width_out_a : serial_a.clk_level;
        periph_own[SHPR_BIT_CLK_B]   = pulse_width_out_b_enable
                                       | serial_b.clk_out_en | serial_b.clk_in_en;
        periph_drive[SHPR_BIT_CLK_B] = pulse_width_out_b_enable | serial_b.clk_out_en;
        periph_val[SHPR_BIT_CLK_B]   = pulse_width_out_b_enable
                                       ? pulse_width_out_b : serial_b.clk_level;
    end

    // Per-pin drive and readback: a claimed pin ignores the latch and the direction bit.
    for (genvar i = 0; i < 8; i++)
    begin : g_pin
        assign drive_en[i]  = periph_own[i] ? periph_drive[i] : st_ff.dir[i];
        assign drive_val[i] = periph_own[i] ? periph_val[i] : st_ff.latch[i];
        // A general output reads back its latch; everything else reads the pin.
        assign port_read[i] = (periph_own[i] || !st_ff.dir[i])
                              ? pin_in[i] : st_ff.latch[i];
    end

    // The four-bit analog port has no direction register and reserved upper bits.
    shpr_analog_readback #(
        .WIDTH    (4),
        .FILL     (SHPR_AN4_FILL),
        .IS_EIGHT (1'b0)
    ) u_an4 (
        .pin_level (analog_four_pin),
        .conv      (conv),
        .level     (an4_level)
    );

    // The eight-bit analog port, likewise input only.
    shpr_analog_readback #(
        .WIDTH    (8),
        .FILL     (SHPR_AN8_FILL),
        .IS_EIGHT (1'b1)
    ) u_an8 (
        .pin_level (analog_eight_pin),
        .conv      (conv),
        .level     (an8_level)
    );

    // Next state: APB slave, register updates, interrupt flags and registered pin drive.
    always_comb
    begin
        logic       access;
        logic       finish;
        logic [1:0] fall;
        logic [1:0] clr;
        logic [1:0] nxt_stat;
        logic       mapped;

        nxt_st   = st_ff;
        access   = psel && penable;
        finish   = access && st_ff.pready;
        fall     = st_ff.pin_prev & ~pin_in[SHPR_BIT_IRQ_B:SHPR_BIT_IRQ_A];
        clr      = 2'h0;
        mapped   = reg_hit(paddr, SHPR_IDX_DIR)   || reg_hit(paddr, SHPR_IDX_LATCH)
                || reg_hit(paddr, SHPR_IDX_AN4)   || reg_hit(paddr, SHPR_IDX_AN8)
                || reg_hit(paddr, SHPR_IDX_PCTL)  || reg_hit(paddr, SHPR_IDX_ISTAT)
                || reg_hit(paddr, SHPR_IDX_IMASK);

        // Answer one cycle into the access phase; ready stands for a single cycle.
        if (access && !st_ff.pready)
        begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = !mapped;
            nxt_st.prdata  = 32'h0000_0000;
            if (!pwrite)
            begin
                if (reg_hit(paddr, SHPR_IDX_DIR))
                begin
                    nxt_st.prdata = {24'h00_0000, SHPR_DIR_READ};
                end
                else if (reg_hit(paddr, SHPR_IDX_LATCH))
                begin
                    nxt_st.prdata = {24'h00_0000, port_read};
                end
                else if (reg_hit(paddr, SHPR_IDX_AN4))
                begin
                    nxt_st.prdata = {24'h00_0000, an4_level};
                end
                else if (reg_hit(paddr, SHPR_IDX_AN8))
                begin
                    nxt_st.prdata = {24'h00_0000, an8_level};
                end
                else if (reg_hit(paddr, SHPR_IDX_PCTL))
                begin
                    nxt_st.prdata = {24'h00_0000, st_ff.pwm_en, 6'h00}
                                  | {24'h00_0000, SHPR_PCTL_RSVD};
                end
                else if (reg_hit(paddr, SHPR_IDX_ISTAT))
                begin
                    nxt_st.prdata = {30'h0000_0000, st_ff.int_stat};
                end
                else if (reg_hit(paddr, SHPR_IDX_IMASK))
                begin
                    nxt_st.prdata = {30'h0000_0000, st_ff.int_mask};
                end
                else
                begin
                    nxt_st.prdata = 32'h0000_0000;
                end
            end
        end
        else
        begin
            nxt_st.pready  = 1'b0;
            nxt_st.pslverr = 1'b0;
        end

        // Writes land at the edge that completes the transfer.
        if (finish && pwrite)
        begin
            if (reg_hit(paddr, SHPR_IDX_DIR))
            begin
                nxt_st.dir = pwdata[7:0];
            end
            else if (reg_hit(paddr, SHPR_IDX_LATCH))
            begin
                // The latch is written even for pins that do not drive it out.
                nxt_st.latch = pwdata[7:0];
            end
            else if (reg_hit(paddr, SHPR_IDX_PCTL))
            begin
                nxt_st.pwm_en = {pwdata[SHPR_PCTL_PWM_B], pwdata[SHPR_PCTL_PWM_A]};
            end
            else if (reg_hit(paddr, SHPR_IDX_ISTAT))
            begin
                clr = pwdata[1:0];
            end
            else if (reg_hit(paddr, SHPR_IDX_IMASK))
            begin
                nxt_st.int_mask = pwdata[1:0];
            end
            else
            begin
                // Analog port writes are accepted and dropped without error.
                nxt_st.dir = st_ff.dir;
            end
        end

        // Falling edges on the interrupt pins, including edges the latch itself drives.
        // The set term wins over a clear written in the same cycle.
        nxt_st.pin_prev = pin_in[SHPR_BIT_IRQ_B:SHPR_BIT_IRQ_A];
        nxt_stat        = (st_ff.int_stat & ~clr) | fall;
        nxt_st.int_stat = nxt_stat;
        nxt_st.irq      = |(nxt_stat & nxt_st.int_mask);

        // Pin levels handed on to the interrupt controller, converter and serial channels.
        nxt_st.ext_irq = pin_in[SHPR_BIT_IRQ_B:SHPR_BIT_IRQ_A];
        nxt_st.trig    = pin_in[SHPR_BIT_IRQ_B];
        nxt_st.rx      = {pin_in[SHPR_BIT_RX_B], pin_in[SHPR_BIT_RX_A]};
        nxt_st.clk_in  = {pin_in[SHPR_BIT_CLK_B], pin_in[SHPR_BIT_CLK_A]};

        // Pin drive is registered so the pads switch cleanly after the edge.
        nxt_st.pin_out  = drive_val;
        nxt_st.pin_oe_n = ~drive_en;
    end

    // State register; reset loads constants only.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= SHPR_STATE_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Every output comes straight from the state register.
    assign prdata                = st_ff.prdata;
    assign pready                = st_ff.pready;
    assign pslverr               = st_ff.pslverr;
    assign irq                   = st_ff.irq;
    assign pin_out               = st_ff.pin_out;
    assign pin_oe_n              = st_ff.pin_oe_n;
    assign ext_interrupt_in_a    = st_ff.ext_irq[SHPR_INT_A];
    assign ext_interrupt_in_b    = st_ff.ext_irq[SHPR_INT_B];
    assign converter_ext_trigger = st_ff.trig;
    assign serial_rx_in_a        = st_ff.rx[0];
    assign serial_rx_in_b        = st_ff.rx[1];
    assign serial_clk_pin_a      = st_ff.clk_in[0];
    assign serial_clk_pin_b      = st_ff.clk_in[1];

endmodule : shpr_port

`default_nettype wire

// >>> shpr_monitor.sv
// Checker for the shared port block: bus handshake, analog reads, pin copies and interrupt.
`default_nettype none
module shpr_monitor (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 irq,
    input wire logic [7:0]           pin_in,
    input wire logic [3:0]           analog_four_pin,
    input wire logic [7:0]           analog_eight_pin,
    input wire shpr_pkg::shpr_conv_t conv,
    input wire logic                 ext_interrupt_in_a,
    input wire logic                 serial_rx_in_a
);
    timeunit 1ns;
    timeprecision 1ps;
    import shpr_pkg::*;
    localparam logic [31:0] A_DIR = {14'h0, SHPR_IDX_DIR, 2'h0};
    localparam logic [31:0] A_AN4 = {14'h0, SHPR_IDX_AN4, 2'h0};
    localparam logic [31:0] A_AN8 = {14'h0, SHPR_IDX_AN8, 2'h0};
    logic [7:0] samp;
    logic [7:0] an4_exp_ff;
    logic [7:0] an8_exp_ff;
    logic       rd_done;
    logic       bus_wr;

    // Read data is taken at the same edge that raises pready, so the reference lags the pins by one edge.
    assign samp    = conv.active ? (8'h01 << conv.chan) : 8'h00;
    assign rd_done = pready && !pwrite;
    assign bus_wr  = psel && penable && pwrite;
    always_ff @(posedge pclk)
    begin
        an4_exp_ff <= {4'hf, analog_four_pin | (conv.on_eight ? 4'h0 : samp[3:0])};
        an8_exp_ff <= analog_eight_pin | (conv.on_eight ? samp : 8'h00);
    end

    // All checks share one clock and the asynchronous reset.
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ready_once: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("pready did not pulse once after the access phase");
    chk_err_paired: assert property (pslverr |-> pready)
        else $error("pslverr seen without pready");
    chk_analog_wr_ok: assert property (pready && pwrite && (paddr == A_AN4 || paddr == A_AN8)
        |-> !pslverr)
        else $error("write to an input-only register raised an error");
    chk_four_read: assert property (rd_done && paddr == A_AN4 |-> prdata == {24'h0, an4_exp_ff})
        else $error("four-bit port read data wrong");
    chk_eight_read: assert property (rd_done && paddr == A_AN8 |-> prdata == {24'h0, an8_exp_ff})
        else $error("eight-bit port read data wrong");
    chk_dir_ones: assert property (rd_done && paddr == A_DIR |-> prdata == 32'h0000_00ff)
        else $error("direction register did not read all ones");
    chk_irq_pin_copy: assert property ($past(presetn) |-> ext_interrupt_in_a == $past(pin_in[0]))
        else $error("interrupt pin copy does not follow the pin");
    chk_rx_pin_copy: assert property ($past(presetn) |-> serial_rx_in_a == $past(pin_in[3]))
        else $error("receive pin copy does not follow the pin");
    chk_irq_cause: assert property ($rose(irq) |-> (($past(pin_in[1:0], 2) & ~$past(pin_in[1:0]))
        != 2'h0) || $past(bus_wr))
        else $error("interrupt rose with no falling edge or write");
    chk_irq_drop: assert property ($fell(irq) |-> $past(bus_wr))
        else $error("interrupt fell without a register write");

    // Main scenarios that the bench is expected to reach.
    cover property (pready && pslverr);
    cover property ($rose(irq));
    cover property (rd_done && paddr == A_AN8 && conv.active);
endmodule : shpr_monitor

bind shpr_port shpr_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .pin_in(pin_in), .analog_four_pin(analog_four_pin),
    .analog_eight_pin(analog_eight_pin), .conv(conv),
    .ext_interrupt_in_a(ext_interrupt_in_a), .serial_rx_in_a(serial_rx_in_a));
`default_nettype wire

// >>> shpr_pins.sv
// Far-side model of the bidirectional pins: outside drivers and the resolved pin level.
`default_nettype none
module shpr_pins (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] ext_lvl,
    input  wire logic       clash,
    output logic      [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pin shows the block's value; clash models a stronger outside driver winning.
    always_comb pin_in = clash ? ext_lvl : ((pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n));
endmodule : shpr_pins
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the shared port block: registers, pins, analog reads, interrupt.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import shpr_pkg::*;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0]  paddr, pwdata, prdata, rd_data;
    logic [7:0]   pin_in, pin_out, pin_oe_n, ext_lvl, an8;
    logic [3:0]   an4;
    logic [4:0]   side_out;
    logic         clash, pw_a, pw_b, rx_a, rd_err;
    shpr_serial_t ser_a, ser_b;
    shpr_conv_t   conv;
    int           num_errors, n_tests;

    shpr_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .analog_four_pin(an4), .analog_eight_pin(an8), .serial_a(ser_a), .serial_b(ser_b),
        .pulse_width_out_a(pw_a), .pulse_width_out_b(pw_b), .conv(conv),
        .ext_interrupt_in_a(), .ext_interrupt_in_b(side_out[4]),
        .converter_ext_trigger(side_out[3]), .serial_rx_in_a(rx_a),
        .serial_rx_in_b(side_out[2]), .serial_clk_pin_a(side_out[0]),
        .serial_clk_pin_b(side_out[1]));
    shpr_pins u_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl), .clash(clash),
        .pin_in(pin_in));

    // Free-running 100 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    // One transfer; the request is held until pready is seen high, however long that takes.
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {14'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd_data, exp);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic t_reset_and_input();
        chk({24'h0, pin_oe_n}, 32'hff);
        rd(SHPR_IDX_DIR, 32'hff);
        ext_lvl <= 8'hc3;
        wr(SHPR_IDX_LATCH, 8'h3c);
        tick(2);
        chk({24'h0, pin_oe_n}, 32'hff);
        rd(SHPR_IDX_LATCH, 32'hc3);
        // Pin copies handed to the peripherals follow the input pins.
        chk({27'h0, side_out}, 32'h1b);
    endtask : t_reset_and_input

    // An outside driver fights the pins, so the read must still give the latch.
    task automatic t_output();
        wr(SHPR_IDX_DIR, 8'hff);
        wr(SHPR_IDX_LATCH, 8'ha5);
        clash   <= 1'b1;
        ext_lvl <= 8'h5a;
        tick(3);
        chk({24'h0, pin_out}, 32'ha5);
        chk({24'h0, pin_oe_n}, 32'h00);
        rd(SHPR_IDX_LATCH, 32'ha5);
        rd(SHPR_IDX_DIR, 32'hff);
        clash <= 1'b0;
    endtask : t_output

    // Transmit drives low against a latch of ones; receive and clock-in hold a break low.
    task automatic t_serial();
        wr(SHPR_IDX_LATCH, 8'hff);
        ext_lvl <= 8'h00;
        ser_a   <= '{tx_en: 1'b1, rx_en: 1'b1, default: 1'b0};
        ser_b   <= '{clk_in_en: 1'b1, default: 1'b0};
        tick(3);
        chk({24'h0, pin_oe_n}, 32'h88);
        chk({24'h0, pin_out | 8'h88}, 32'hfb);
        rd(SHPR_IDX_LATCH, 32'h73);
        chk({31'h0, rx_a}, 32'h0);
        ser_a <= '0;
        ser_b <= '0;
    endtask : t_serial

    // PWM outranks the serial clock output and the latch on the top two pins.
    task automatic t_pwm();
        wr(SHPR_IDX_PCTL, 8'hc0);
        ser_a <= '{clk_out_en: 1'b1, clk_level: 1'b1, default: 1'b0};
        pw_a  <= 1'b0;
        pw_b  <= 1'b0;
        tick(3);
        chk({24'h0, pin_oe_n}, 32'h00);
        rd(SHPR_IDX_LATCH, 32'h3f);
        rd(SHPR_IDX_PCTL, 32'hfe);
        pw_a <= 1'b1;
        tick(3);
        chk({24'h0, pin_out}, 32'h7f);
        ser_a <= '0;
        wr(SHPR_IDX_PCTL, 8'h00);
    endtask : t_pwm

    // Each channel number from 0 to 7 is sampled once; odd steps target the eight-bit port.
    task automatic t_analog();
        an4 <= 4'h5;
        an8 <= 8'h3c;
        for (int k = 0; k < 8; k++)
        begin
            conv <= '{active: 1'b1, on_eight: k[0], chan: k[2:0]};
            rd(SHPR_IDX_AN4, {24'h0, 4'hf, 4'h5 | (k[0] ? 4'h0 : 4'h1 << k)});
            rd(SHPR_IDX_AN8, {24'h0, 8'h3c | (k[0] ? 8'h1 << k : 8'h0)});
        end
        conv <= '0;
        an4  <= 4'ha;
        rd(SHPR_IDX_AN4, 32'hfa);
        wr(SHPR_IDX_AN4, 8'h00);
        chk({31'h0, rd_err}, 32'h0);
        wr(SHPR_IDX_AN8, 8'hff);
        chk({31'h0, rd_err}, 32'h0);
        rd(SHPR_IDX_AN4, 32'hfa);
        rd(SHPR_IDX_AN8, 32'h3c);
        rd(16'hfe90, 32'h0);
        chk({31'h0, rd_err}, 32'h1);
    endtask : t_analog

    // Output falling edges on both interrupt pins; then clear one and mask the other.
    task automatic t_irq();
        wr(SHPR_IDX_ISTAT, 8'h03);
        wr(SHPR_IDX_IMASK, 8'h03);
        wr(SHPR_IDX_LATCH, 8'hfc);
        tick(3);
        chk({31'h0, irq}, 32'h1);
        rd(SHPR_IDX_ISTAT, 32'h03);
        wr(SHPR_IDX_ISTAT, 8'h01);
        rd(SHPR_IDX_ISTAT, 32'h02);
        chk({31'h0, irq}, 32'h1);
        wr(SHPR_IDX_IMASK, 8'h01);
        tick(2);
        chk({31'h0, irq}, 32'h0);
    endtask : t_irq

    // Time-zero values, reset, then the scenarios in order.
    initial
    begin
        {presetn, psel, penable, pwrite, clash, pw_a, pw_b} = '0;
        {paddr, pwdata, an4, an8} = '0;
        ext_lvl    = 8'hff;
        ser_a      = '0;
        ser_b      = '0;
        conv       = '0;
        num_errors = 0;
        n_tests    = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_and_input();
        t_output();
        t_serial();
        t_pwm();
        t_analog();
        t_irq();
        tally_and_finish();
    end

    // The scenarios need a few hundred cycles; this limit cuts a hung handshake short.
    initial
    begin
        #50us;
        num_errors++;
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
